/* hdl/pipc_pkg.sv */
/*
 Constants for the pin input select and power control register bank.
 Assumes a register access port of 16-bit words with a small address.
*/
`default_nettype none
package pipc_pkg;
   localparam int          ADDR_W          = 4;
   localparam int          DATA_W          = 16;
   localparam int          NUM_PINS        = 8;
   localparam logic [3:0]  ADDR_INPUT_SEL  = 4'h5;
   localparam logic [3:0]  ADDR_PWR_CTRL   = 4'hB;
   localparam logic [15:0] INPUT_SEL_RST   = 16'h0000;
   localparam logic [15:0] PWR_CTRL_RST    = 16'h0000;
   localparam logic [15:0] INPUT_SEL_MASK  = 16'h00FF;
   localparam logic [15:0] PWR_CTRL_MASK   = 16'h06FF;
   localparam int          GLOBAL_PD_BIT   = 10;
   localparam int          REF_EN_BIT      = 9;
   localparam int          CH_PD_LSB       = 0;
   localparam int          IN_SEL_LSB      = 0;
endpackage : pipc_pkg
`default_nettype wire

/* hdl/pipc_if.sv */
/*
 Carrier between the register bank and the power decode.
 Assumes both ends share the bank clock.
*/
`default_nettype none
interface pipc_if;
   logic       global_pd;
   logic       ref_en;
   logic [7:0] ch_pd;
   logic [7:0] is_dac;
   logic       ref_pwr;
   logic       adc_pwr;
   logic [7:0] dac_pwr;
   modport bank (output global_pd, ref_en, ch_pd, is_dac,
                 input ref_pwr, adc_pwr, dac_pwr);
   modport dec (input global_pd, ref_en, ch_pd, is_dac,
                output ref_pwr, adc_pwr, dac_pwr);
endinterface : pipc_if
`default_nettype wire

/* hdl/pipc_pwr_dec.sv */
/*
 Power state decode from the control bits.
 Assumes inputs come straight from registers on the same clock.
*/
`default_nettype none
module pipc_pwr_dec
   import pipc_pkg::*;
(
   pipc_if.dec p
);
   always_comb begin
      p.ref_pwr = !p.global_pd && p.ref_en;
      p.adc_pwr = !p.global_pd;
      p.dac_pwr = p.global_pd ? 8'h00 : ~(p.ch_pd & p.is_dac);
   end
endmodule : pipc_pwr_dec
`default_nettype wire

/* hdl/pipc_top.sv */
/*
 Pin input select and power control register bank.
 Assumes the serial front end issues one-cycle write and read strobes on
 i_mclk with a register address; read data is registered.
// Operation
// - input select bit n set makes pin n a digital input
// - input select bit clear leaves pin function to pin config
// - global power-down turns off reference, all DACs and ADC
// - without global power-down, reference and DACs follow their own bits
// - reference enable clear keeps reference and buffer off, reset state
// - reference enable set powers reference and drives reference pin
// - channel power-down bit powers channel down only when it is a DAC
// - channel power-down bit clear keeps channel in normal mode
*/
`default_nettype none
module pipc_top
   import pipc_pkg::*;
(
   input  wire logic              i_mclk,
   input  wire logic              i_rst,
   input  wire logic              i_wr_en,
   input  wire logic              i_rd_en,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_wdata,
   input  wire logic [7:0]        i_pin_is_dac,
   output logic      [DATA_W-1:0] o_rdata,
   output logic      [7:0]        o_pin_input_en,
   output logic                   o_ref_power,
   output logic                   o_ref_pin_drive,
   output logic                   o_adc_power,
   output logic      [7:0]        o_dac_power
);
   logic [DATA_W-1:0] pin_input_select;
   logic [DATA_W-1:0] power_and_reference_control;
   logic [DATA_W-1:0] rdata;
   logic [DATA_W-1:0] next_pin_input_select;
   logic [DATA_W-1:0] next_power_and_reference_control;
   logic [DATA_W-1:0] next_rdata;
   pipc_if pif ();
   logic              wr_insel;
   logic              wr_pwr;

   // one address compare shared by the write path and checks; the read path decodes with a case
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] r);
      return a == r;
   endfunction : addr_hit

   // reserved positions are cut on the way in, so reads need no mask
   function automatic logic [DATA_W-1:0] keep_fields(
      input logic [DATA_W-1:0] v,
      input logic [DATA_W-1:0] m
   );
      return v & m;
   endfunction : keep_fields

   assign wr_insel = i_wr_en && addr_hit(i_addr, ADDR_INPUT_SEL);
   assign wr_pwr   = i_wr_en && addr_hit(i_addr, ADDR_PWR_CTRL);

   // a read in the cycle of a write returns the old word; the host needs
   // no turnaround gap, the new value shows from the next read on
   always_comb begin
      next_pin_input_select            = pin_input_select;
      next_power_and_reference_control = power_and_reference_control;
      next_rdata                       = rdata;
      if (wr_insel) begin
         next_pin_input_select = keep_fields(i_wdata, INPUT_SEL_MASK);
      end
      if (wr_pwr) begin
         next_power_and_reference_control =
            keep_fields(i_wdata, PWR_CTRL_MASK);
      end
      if (i_rd_en) begin
         unique case (i_addr)
            ADDR_INPUT_SEL: next_rdata = pin_input_select;
            ADDR_PWR_CTRL:  next_rdata = power_and_reference_control;
            default:        next_rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         pin_input_select            <= INPUT_SEL_RST;
         power_and_reference_control <= PWR_CTRL_RST;
         rdata                       <= 16'h0000;
      end else begin
         pin_input_select            <= next_pin_input_select;
         power_and_reference_control <= next_power_and_reference_control;
         rdata                       <= next_rdata;
      end
   end

   // register bank: masked store, hold between writes, registered read
   insel_store_a: assert property (
      @(posedge i_mclk) disable iff (i_rst)
      wr_insel |=>
         pin_input_select == ($past(i_wdata) & INPUT_SEL_MASK))
      else $error("input select word not stored");

   pwr_store_a: assert property (
      @(posedge i_mclk) disable iff (i_rst)
      wr_pwr |=>
         power_and_reference_control == ($past(i_wdata) & PWR_CTRL_MASK))
      else $error("power control word not stored");

   insel_hold_a: assert property (
      @(posedge i_mclk) disable iff (i_rst)
      !wr_insel |=> $stable(pin_input_select))
      else $error("input select changed without a write");

   pwr_hold_a: assert property (
      @(posedge i_mclk) disable iff (i_rst)
      !wr_pwr |=> $stable(power_and_reference_control))
      else $error("power control changed without a write");

   rd_insel_a: assert property (
      @(posedge i_mclk) disable iff (i_rst)
      (i_rd_en && addr_hit(i_addr, ADDR_INPUT_SEL)) |=>
         o_rdata == $past(pin_input_select))
      else $error("input select read back wrong");

   rd_pwr_a: assert property (
      @(posedge i_mclk) disable iff (i_rst)
      (i_rd_en && addr_hit(i_addr, ADDR_PWR_CTRL)) |=>
         o_rdata == $past(power_and_reference_control))
      else $error("power control read back wrong");

   rd_unmapped_a: assert property (
      @(posedge i_mclk) disable iff (i_rst)
      (i_rd_en && !addr_hit(i_addr, ADDR_INPUT_SEL) &&
       !addr_hit(i_addr, ADDR_PWR_CTRL)) |=> o_rdata == 16'h0000)
      else $error("unmapped read not zero");

   assign pif.global_pd = power_and_reference_control[GLOBAL_PD_BIT];
   assign pif.ref_en    = power_and_reference_control[REF_EN_BIT];
   assign pif.ch_pd     = power_and_reference_control[CH_PD_LSB +: 8];
   // dac flag is combinational from the pin config bank on our clock
   assign pif.is_dac    = i_pin_is_dac;

   pipc_pwr_dec u_dec (
      .p (pif.dec)
   );

   // unselected pins stay low so pin config decides their use
   assign o_pin_input_en  = pin_input_select[IN_SEL_LSB +: 8];
   assign o_ref_power     = pif.ref_pwr;
   assign o_ref_pin_drive = pif.ref_pwr;
   assign o_adc_power     = pif.adc_pwr;
   assign o_dac_power     = pif.dac_pwr;
   assign o_rdata         = rdata;

   input_sel_a: assert property (
      @(posedge i_mclk) disable iff (i_rst)
      wr_insel |=>
         o_pin_input_en == $past(i_wdata[IN_SEL_LSB +: 8]))
      else $error("input select did not follow write");

   input_clr_a: assert property (
      @(posedge i_mclk) disable iff (i_rst)
      (wr_insel && i_wdata[3] == 1'b0) |=>
         !o_pin_input_en[3])
      else $error("cleared select still forces input");

   global_pd_a: assert property (
      @(posedge i_mclk) disable iff (i_rst)
      power_and_reference_control[GLOBAL_PD_BIT] |->
         !o_ref_power && !o_adc_power && o_dac_power == 8'h00)
      else $error("global power-down left something on");

   ref_follow_a: assert property (
      @(posedge i_mclk) disable iff (i_rst)
      (wr_pwr && !i_wdata[GLOBAL_PD_BIT]) |=>
         o_ref_power == $past(i_wdata[REF_EN_BIT]))
      else $error("reference did not follow enable");

   adc_on_a: assert property (
      @(posedge i_mclk) disable iff (i_rst)
      !power_and_reference_control[GLOBAL_PD_BIT] |-> o_adc_power)
      else $error("converter off without global power-down");

   ref_off_a: assert property (
      @(posedge i_mclk) disable iff (i_rst)
      !power_and_reference_control[REF_EN_BIT] |->
         !o_ref_power && !o_ref_pin_drive)
      else $error("reference on while disabled");

   ref_on_a: assert property (
      @(posedge i_mclk) disable iff (i_rst)
      (power_and_reference_control[REF_EN_BIT] &&
       !power_and_reference_control[GLOBAL_PD_BIT]) |->
         o_ref_power && o_ref_pin_drive)
      else $error("reference pin not driven");

   ref_pin_a: assert property (
      @(posedge i_mclk) disable iff (i_rst)
      o_ref_pin_drive == o_ref_power)
      else $error("reference pin and buffer disagree");

   ch_pd_a: assert property (
      @(posedge i_mclk) disable iff (i_rst)
      (!power_and_reference_control[GLOBAL_PD_BIT] && !i_pin_is_dac[2])
         |-> o_dac_power[2])
      else $error("non-dac channel powered down");

   ch_down_a: assert property (
      @(posedge i_mclk) disable iff (i_rst)
      (!power_and_reference_control[GLOBAL_PD_BIT] &&
       power_and_reference_control[CH_PD_LSB + 2] && i_pin_is_dac[2])
         |-> !o_dac_power[2])
      else $error("dac channel not powered down");

   ch_norm_a: assert property (
      @(posedge i_mclk) disable iff (i_rst)
      (!power_and_reference_control[GLOBAL_PD_BIT] &&
       !power_and_reference_control[CH_PD_LSB + 5])
         |-> o_dac_power[5])
      else $error("channel not in normal mode");

   rsvd_zero_a: assert property (
      @(posedge i_mclk) disable iff (i_rst)
      i_rd_en |=>
         (o_rdata & ~(INPUT_SEL_MASK | PWR_CTRL_MASK)) == 16'h0000)
      else $error("reserved bits read nonzero");
endmodule : pipc_top
`default_nettype wire

/* dv/pipc_host.sv */
/* Host model for the register port; assumes pipc_top samples on i_mclk. */
`default_nettype none
module pipc_host
   import pipc_pkg::*;
(
   input  wire logic              i_mclk,
   output logic                   o_wr_en,
   output logic                   o_rd_en,
   output logic      [ADDR_W-1:0] o_addr,
   output logic      [DATA_W-1:0] o_wdata
);
   timeunit 1ns / 1ns;
   logic ext_ref = 1'b0; // board feeds its own reference when set
   initial {o_wr_en, o_rd_en, o_addr, o_wdata} = '0;
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      if (ext_ref && a == ADDR_PWR_CTRL)
         v[REF_EN_BIT] = 1'b0;
      @(posedge i_mclk) #1;
      {o_addr, o_wdata, o_wr_en} = {a, v, 1'b1};
      @(posedge i_mclk) #1;
      {o_addr, o_wdata, o_wr_en} = {~a, ~v, 1'b0}; // no stale data
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge i_mclk) #1;
      {o_addr, o_rd_en} = {a, 1'b1};
      @(posedge i_mclk) #1;
      {o_addr, o_rd_en} = {~a, 1'b0};
   endtask : rd
endmodule : pipc_host
`default_nettype wire

/* dv/pipc_top_bench.sv */
/* Self-checking bench for pipc_top; assumes pipc_host drives its port. */
`default_nettype none
module pipc_top_bench
   import pipc_pkg::*;
();
   timeunit 1ns / 1ns;
   logic              mclk = 1'b0, rst = 1'b1, wr, rd, ref_p, ref_d, adc_p;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata;
   logic [7:0]        is_dac = 8'h00, in_en, dac_p;
   int                n_mismatch = 0, check_count = 0;
   wire logic [10:0]  pw = {ref_p, ref_d, adc_p, dac_p};
   always #50 mclk = ~mclk;
   pipc_top i_pipc_top (.i_mclk(mclk), .i_rst(rst), .i_wr_en(wr),
      .i_rd_en(rd), .i_addr(addr), .i_wdata(wdata), .i_pin_is_dac(is_dac),
      .o_rdata(rdata), .o_pin_input_en(in_en), .o_ref_power(ref_p),
      .o_ref_pin_drive(ref_d), .o_adc_power(adc_p), .o_dac_power(dac_p));
   pipc_host i_pipc_host (.i_mclk(mclk), .o_wr_en(wr), .o_rd_en(rd),
      .o_addr(addr), .o_wdata(wdata));
   task automatic chk(input logic [31:0] s, e);
      check_count++;
      if (s !== e) $display("Error %0t: saw %h want %h", $time, s, e);
      n_mismatch += int'(s !== e);
   endtask : chk
   task automatic end_sim(input int late);
      n_mismatch += late;
      $display("errors %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_sim
   task automatic t_reset;
      i_pipc_host.wr(4'h0, 16'hFFFF);
      i_pipc_host.rd(4'h0);
      chk({rdata, 5'h00, pw}, 32'h0000_01FF);
      i_pipc_host.rd(ADDR_INPUT_SEL);
      chk({rdata, 8'h00, in_en}, {INPUT_SEL_RST, 16'h0000});
   endtask : t_reset
   task automatic t_insel;
      for (int n = 0; n < NUM_PINS; n++) begin
         i_pipc_host.wr(ADDR_INPUT_SEL, 16'hFF00 | (16'h1 << n));
         i_pipc_host.rd(ADDR_INPUT_SEL);
         chk({rdata, 8'h00, in_en}, {2{16'h1 << n}});
      end
   endtask : t_insel
   task automatic t_pwr;
      is_dac = 8'h0F;
      i_pipc_host.wr(ADDR_PWR_CTRL, 16'hFBA5);
      i_pipc_host.rd(ADDR_PWR_CTRL);
      chk({rdata, 5'h00, pw}, 32'h02A5_07FA);
      is_dac = 8'hFF;
      #1 chk({21'h0, pw}, 32'h0000_075A);
      i_pipc_host.wr(ADDR_PWR_CTRL, 16'h06FF);
      chk({21'h0, pw}, 32'h0000_0000);
   endtask : t_pwr
   task automatic t_rerst;
      rst = 1'b1;
      @(posedge mclk) #1 rst = 1'b0;
      chk({rdata, 8'h00, in_en}, 32'h0000_0000);
      chk({21'h0, pw}, 32'h0000_01FF);
      i_pipc_host.rd(ADDR_PWR_CTRL);
      chk({rdata, 16'h0000}, {PWR_CTRL_RST, 16'h0000});
   endtask : t_rerst
   task automatic t_extref;
      i_pipc_host.ext_ref = 1'b1;
      i_pipc_host.wr(ADDR_PWR_CTRL, 16'h02C3);
      i_pipc_host.rd(ADDR_PWR_CTRL);
      chk({rdata, 5'h00, pw}, 32'h00C3_013C);
      i_pipc_host.ext_ref = 1'b0;
   endtask : t_extref
   initial begin
      repeat (16) @(posedge mclk);
      #1 rst = 1'b0;
      t_reset();
      t_insel();
      t_pwr();
      t_rerst();
      t_extref();
      end_sim(0);
   end
   initial #50us end_sim(1);
endmodule : pipc_top_bench
`default_nettype wire
